// File: logic/cmp_mode_defines.vh
// constants for the comparator mode-control block
`ifndef CMP_MODE_DEFINES_VH
`define CMP_MODE_DEFINES_VH
`define ADDR_W 8
`define OFF_MODE 8'h00
`define OFF_STATUS 8'h04
`define OFF_MASK 8'h08
`define OFF_SEL 8'h0c
`define OFF_LEVEL 8'h10
`define BIT_INV 6
`define BIT_RIE 5
`define BIT_FIE 4
`define FLD_INPUT_ROUTING_SELECT_HI 3
`define FLD_INPUT_ROUTING_SELECT_LO 2
`define FLD_MD_HI 1
`define FLD_MD_LO 0
`define MODE_RESET 8'h02
`define SEL_RESET 8'hff
`define MD_RESET 2'h2
`define SEL_NIB_RESET 4'hf
`define LEVEL_RESET 6'h00
`define MASK_RESET 2'h0
`define INPUT_ROUTING_SELECT_DIRECT 2'h0
`define INPUT_ROUTING_SELECT_GND 2'h1
`define INPUT_ROUTING_SELECT_DAC_PLUS 2'h2
`define INPUT_ROUTING_SELECT_DAC_MINUS 2'h3
`define MD_FASTEST 2'h0
`define MD_SLOWEST 2'h3
`define ST_RISE 0
`define ST_FALL 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: logic/cmp_sync3.v
// three-flop synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module cmp_sync3 (
   input wire clk_in,
   input wire nrst_in,
   input wire d_in,
   output reg q_out
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         q_out <= 1'b0;
      end else begin
         s1_ff <= d_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            q_out <= s3_ff;
         end
      end
   end
endmodule // cmp_sync3

// File: logic/cmp_edge_flag.v
// sticky edge flag, set wins over a write-one clear
`timescale 1ns/1ps
module cmp_edge_flag (
   input wire clk_in,
   input wire nrst_in,
   input wire set_in,
   input wire clr_in,
   output reg flag_out
);
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flag_out <= 1'b0;
      end else if (set_in) begin
         flag_out <= 1'b1;
      end else if (clr_in) begin
         flag_out <= 1'b0;
      end
   end
endmodule // cmp_edge_flag

// File: logic/comparator_mode_control.v
// comparator mode-control register bank with AXI4-Lite slave
// Summary of operation
// - rise_irq_enable (bit 5) lets a rising edge raise the interrupt, otherwise not.
// - fall_irq_enable (bit 4) lets a falling edge raise the interrupt, otherwise not.
// - routing 0x0 drives plus from the positive selection and minus from the negative one, DAC off.
// - routing 0x1 drives plus from the positive selection and ties minus to ground, DAC off.
// - routing 0x2 feeds the DAC to plus, negative selection to minus, positive selection as DAC reference.
// - routing 0x3 feeds the DAC to minus, positive selection to plus, negative selection as DAC reference.
// - speed_power_mode in bits 1:0 resets to 0x2 and is presented to the comparator.
// - mode 0x0 requests the fastest response at highest power.
// - mode 0x3 requests the slowest response at lowest power, 0x1 and 0x2 lie between.
// - a rising comparator output sets the rise flag, which stays until firmware clears it.
// - a falling comparator output sets the fall flag, which stays until firmware clears it.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cmp_mode_defines.vh"
module comparator_mode_control (
   input wire CORE_CLK_IN,
   input wire NRST_IN,
   input wire [7:0] S_AXI_AWADDR_IN,
   input wire S_AXI_AWVALID_IN,
   output wire S_AXI_AWREADY_OUT,
   input wire [31:0] S_AXI_WDATA_IN,
   input wire [3:0] S_AXI_WSTRB_IN,
   input wire S_AXI_WVALID_IN,
   output wire S_AXI_WREADY_OUT,
   output reg [1:0] S_AXI_BRESP_OUT,
   output reg S_AXI_BVALID_OUT,
   input wire S_AXI_BREADY_IN,
   input wire [7:0] S_AXI_ARADDR_IN,
   input wire S_AXI_ARVALID_IN,
   output wire S_AXI_ARREADY_OUT,
   output reg [31:0] S_AXI_RDATA_OUT,
   output reg [1:0] S_AXI_RRESP_OUT,
   output reg S_AXI_RVALID_OUT,
   input wire S_AXI_RREADY_IN,
   input wire CMP_RAW_IN,
   output reg CMP_OUT,
   output reg [1:0] SPEED_POWER_MODE_OUT,
   output reg FASTEST_MODE_OUT,
   output reg SLOWEST_MODE_OUT,
   output reg [3:0] PLUS_MUX_SEL_OUT,
   output reg PLUS_FROM_DAC_OUT,
   output reg [3:0] MINUS_MUX_SEL_OUT,
   output reg MINUS_FROM_DAC_OUT,
   output reg MINUS_TO_GND_OUT,
   output reg DAC_ENABLE_OUT,
   output reg [3:0] DAC_REF_SEL_OUT,
   output reg [5:0] DAC_LEVEL_OUT,
   output wire IRQ_OUT
);
   ////////////////////////////////////////////////////////////////////////////
   // register map, one aligned word each, only the low byte is implemented:
   //   mode   - invert, rise enable, fall enable, routing, speed/power mode
   //   status - rise and fall event flags, write one to clear
   //   mask   - per-flag gate on the interrupt, on top of the mode enables
   //   sel    - negative selection in the high nibble, positive in the low one
   //   level  - dac reference level, six bits
   //   other offsets are answered with slverr and have no effect
   // registers
   reg [7:0] mode_ff;
   reg [7:0] sel_ff;
   reg [5:0] level_ff;
   reg [1:0] mask_ff;
   reg [7:0] aw_addr_ff;
   reg aw_got_ff;
   reg [31:0] w_data_ff;
   reg [3:0] w_strb_ff;
   reg w_got_ff;
   reg cmp_prev_ff;
   wire cmp_sync;
   wire cmp_pol;
   wire rise_event_flag;
   wire fall_event_flag;
   wire [1:0] status;
   wire wr_fire;
   wire wr_hit_status;
   wire [1:0] clr_bits;
   wire [1:0] input_routing_select;
   reg [31:0] nxt_rdata;
   reg nxt_rerr;
   wire rise_seen;
   wire fall_seen;
   wire rise_irq;
   wire fall_irq;
   reg irq_ff;

   assign input_routing_select = mode_ff[`FLD_INPUT_ROUTING_SELECT_HI:`FLD_INPUT_ROUTING_SELECT_LO];

   ////////////////////////////////////////////////////////////////////////////
   // comparator output path
   cmp_sync3 u_sync (
      .clk_in(CORE_CLK_IN),
      .nrst_in(NRST_IN),
      .d_in(CMP_RAW_IN),
      .q_out(cmp_sync)
   );

   assign cmp_pol = cmp_sync ^ mode_ff[`BIT_INV];
   // toggling the invert bit flips cmp_pol, and that counts as an edge
   assign rise_seen = cmp_pol & ~cmp_prev_ff;
   assign fall_seen = ~cmp_pol & cmp_prev_ff;

   always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         cmp_prev_ff <= 1'b0;
         CMP_OUT <= 1'b0;
      end else begin
         cmp_prev_ff <= cmp_pol;
         CMP_OUT <= cmp_pol;
      end
   end

   cmp_edge_flag u_rise (
      .clk_in(CORE_CLK_IN),
      .nrst_in(NRST_IN),
      .set_in(rise_seen),
      .clr_in(clr_bits[`ST_RISE]),
      .flag_out(rise_event_flag)
   );

   cmp_edge_flag u_fall (
      .clk_in(CORE_CLK_IN),
      .nrst_in(NRST_IN),
      .set_in(fall_seen),
      .clr_in(clr_bits[`ST_FALL]),
      .flag_out(fall_event_flag)
   );

   assign status = {fall_event_flag, rise_event_flag};

   // enables gate each flag, the mask register gates the result
   assign rise_irq = rise_event_flag & mode_ff[`BIT_RIE] & mask_ff[`ST_RISE];
   assign fall_irq = fall_event_flag & mode_ff[`BIT_FIE] & mask_ff[`ST_FALL];

   // registered so the interrupt pin comes from a flip-flop like the other data outputs
   always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= rise_irq | fall_irq;
      end
   end
   assign IRQ_OUT = irq_ff;

   ////////////////////////////////////////////////////////////////////////////
   // routing and mode decode
   always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         SPEED_POWER_MODE_OUT <= `MD_RESET;
         FASTEST_MODE_OUT <= 1'b0;
         SLOWEST_MODE_OUT <= 1'b0;
         PLUS_MUX_SEL_OUT <= `SEL_NIB_RESET;
         MINUS_MUX_SEL_OUT <= `SEL_NIB_RESET;
         PLUS_FROM_DAC_OUT <= 1'b0;
         MINUS_FROM_DAC_OUT <= 1'b0;
         MINUS_TO_GND_OUT <= 1'b0;
         DAC_ENABLE_OUT <= 1'b0;
         DAC_REF_SEL_OUT <= 4'h0;
         DAC_LEVEL_OUT <= `LEVEL_RESET;
      end else begin
         SPEED_POWER_MODE_OUT <= mode_ff[`FLD_MD_HI:`FLD_MD_LO];
         FASTEST_MODE_OUT <= (mode_ff[`FLD_MD_HI:`FLD_MD_LO] == `MD_FASTEST);
         SLOWEST_MODE_OUT <= (mode_ff[`FLD_MD_HI:`FLD_MD_LO] == `MD_SLOWEST);
         PLUS_MUX_SEL_OUT <= sel_ff[3:0];
         MINUS_MUX_SEL_OUT <= sel_ff[7:4];
         DAC_LEVEL_OUT <= level_ff;
         case (input_routing_select)
            `INPUT_ROUTING_SELECT_DIRECT: begin
               PLUS_FROM_DAC_OUT <= 1'b0;
               MINUS_FROM_DAC_OUT <= 1'b0;
               MINUS_TO_GND_OUT <= 1'b0;
               DAC_ENABLE_OUT <= 1'b0;
               DAC_REF_SEL_OUT <= 4'h0;
            end
            `INPUT_ROUTING_SELECT_GND: begin
               PLUS_FROM_DAC_OUT <= 1'b0;
               MINUS_FROM_DAC_OUT <= 1'b0;
               MINUS_TO_GND_OUT <= 1'b1;
               DAC_ENABLE_OUT <= 1'b0;
               DAC_REF_SEL_OUT <= 4'h0;
            end
            `INPUT_ROUTING_SELECT_DAC_PLUS: begin
               PLUS_FROM_DAC_OUT <= 1'b1;
               MINUS_FROM_DAC_OUT <= 1'b0;
               MINUS_TO_GND_OUT <= 1'b0;
               DAC_ENABLE_OUT <= 1'b1;
               DAC_REF_SEL_OUT <= sel_ff[3:0];
            end
            default: begin
               PLUS_FROM_DAC_OUT <= 1'b0;
               MINUS_FROM_DAC_OUT <= 1'b1;
               MINUS_TO_GND_OUT <= 1'b0;
               DAC_ENABLE_OUT <= 1'b1;
               DAC_REF_SEL_OUT <= sel_ff[7:4];
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write side
   // address and data are held apart, so either may arrive first
   // the write waits for both and for the previous response to be taken
   assign S_AXI_AWREADY_OUT = ~aw_got_ff & ~S_AXI_BVALID_OUT;
   assign S_AXI_WREADY_OUT = ~w_got_ff & ~S_AXI_BVALID_OUT;
   assign wr_fire = aw_got_ff & w_got_ff & ~S_AXI_BVALID_OUT;
   // a clear that meets a new edge loses, so no event is missed
   assign wr_hit_status = wr_fire & (aw_addr_ff == `OFF_STATUS) & w_strb_ff[0];
   assign clr_bits = wr_hit_status ? w_data_ff[1:0] : 2'b00;

   always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         aw_addr_ff <= 8'h00;
         aw_got_ff <= 1'b0;
         w_data_ff <= 32'h00000000;
         w_strb_ff <= 4'h0;
         w_got_ff <= 1'b0;
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT <= `RESP_OKAY;
         mode_ff <= `MODE_RESET;
         sel_ff <= `SEL_RESET;
         level_ff <= `LEVEL_RESET;
         mask_ff <= `MASK_RESET;
      end else begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_addr_ff <= {S_AXI_AWADDR_IN[7:2], 2'b00};
            aw_got_ff <= 1'b1;
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_data_ff <= S_AXI_WDATA_IN;
            w_strb_ff <= S_AXI_WSTRB_IN;
            w_got_ff <= 1'b1;
         end
         if (wr_fire) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= `RESP_OKAY;
            case (aw_addr_ff)
               `OFF_MODE: begin
                  if (w_strb_ff[0]) begin
                     mode_ff <= {1'b0, w_data_ff[6:0]};
                  end
               end
               `OFF_STATUS: begin
               end
               `OFF_MASK: begin
                  if (w_strb_ff[0]) begin
                     mask_ff <= w_data_ff[1:0];
                  end
               end
               `OFF_SEL: begin
                  if (w_strb_ff[0]) begin
                     sel_ff <= w_data_ff[7:0];
                  end
               end
               `OFF_LEVEL: begin
                  if (w_strb_ff[0]) begin
                     level_ff <= w_data_ff[5:0];
                  end
               end
               default: begin
                  S_AXI_BRESP_OUT <= `RESP_SLVERR;
               end
            endcase
         end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read side
   // read data is decoded from the address at the handshake edge and stands until rready
   assign S_AXI_ARREADY_OUT = ~S_AXI_RVALID_OUT;

   always @* begin
      nxt_rdata = 32'h00000000;
      nxt_rerr = 1'b0;
      case ({S_AXI_ARADDR_IN[7:2], 2'b00})
         `OFF_MODE: nxt_rdata[7:0] = mode_ff;
         `OFF_STATUS: nxt_rdata[1:0] = status;
         `OFF_MASK: nxt_rdata[1:0] = mask_ff;
         `OFF_SEL: nxt_rdata[7:0] = sel_ff;
         `OFF_LEVEL: nxt_rdata[5:0] = level_ff;
         default: nxt_rerr = 1'b1;
      endcase
   end

   always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT <= 32'h00000000;
         S_AXI_RRESP_OUT <= `RESP_OKAY;
      end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
         S_AXI_RVALID_OUT <= 1'b1;
         S_AXI_RDATA_OUT <= nxt_rdata;
         S_AXI_RRESP_OUT <= nxt_rerr ? `RESP_SLVERR : `RESP_OKAY;
      end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
         S_AXI_RVALID_OUT <= 1'b0;
      end
   end
endmodule // comparator_mode_control

// File: testbench/comparator_mode_control_asserts.sv
// assertion checker on the comparator mode-control ports
`timescale 1ns/1ps
module comparator_mode_control_asserts (
   input logic CORE_CLK_IN, NRST_IN, FASTEST_MODE_OUT, SLOWEST_MODE_OUT, IRQ_OUT,
   input logic PLUS_FROM_DAC_OUT, MINUS_FROM_DAC_OUT, MINUS_TO_GND_OUT, DAC_ENABLE_OUT,
   input logic [1:0] SPEED_POWER_MODE_OUT,
   input logic [3:0] PLUS_MUX_SEL_OUT, MINUS_MUX_SEL_OUT, DAC_REF_SEL_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   chk_fast_mode: assert property (FASTEST_MODE_OUT == (SPEED_POWER_MODE_OUT == 2'h0)) else $error("fast");
   chk_slow_mode: assert property (SLOWEST_MODE_OUT == (SPEED_POWER_MODE_OUT == 2'h3)) else $error("slow");
   chk_dac_enable: assert property (DAC_ENABLE_OUT == (PLUS_FROM_DAC_OUT || MINUS_FROM_DAC_OUT))
      else $error("dac enable");
   chk_gnd_no_dac: assert property (MINUS_TO_GND_OUT |-> !DAC_ENABLE_OUT) else $error("gnd with dac");
   chk_plus_ref: assert property (PLUS_FROM_DAC_OUT |-> !MINUS_FROM_DAC_OUT && DAC_REF_SEL_OUT == PLUS_MUX_SEL_OUT)
      else $error("plus ref");
   chk_minus_ref: assert property (MINUS_FROM_DAC_OUT |-> !MINUS_TO_GND_OUT && DAC_REF_SEL_OUT == MINUS_MUX_SEL_OUT)
      else $error("minus ref");
   chk_mode_reset: assert property ($rose(NRST_IN) |-> SPEED_POWER_MODE_OUT == 2'h2) else $error("mode reset");
   chk_irq_reset: assert property ($rose(NRST_IN) |-> !IRQ_OUT) else $error("irq reset");
   cover property (PLUS_FROM_DAC_OUT);
   cover property (MINUS_FROM_DAC_OUT);
   cover property (IRQ_OUT);
endmodule // comparator_mode_control_asserts
bind comparator_mode_control comparator_mode_control_asserts chk_u (.CORE_CLK_IN, .NRST_IN, .FASTEST_MODE_OUT,
   .SLOWEST_MODE_OUT, .IRQ_OUT, .PLUS_FROM_DAC_OUT, .MINUS_FROM_DAC_OUT, .MINUS_TO_GND_OUT, .DAC_ENABLE_OUT,
   .SPEED_POWER_MODE_OUT, .PLUS_MUX_SEL_OUT, .MINUS_MUX_SEL_OUT, .DAC_REF_SEL_OUT);

// File: testbench/comparator_mode_control_bench.sv
// self-checking bench for the comparator mode-control block
`timescale 1ns/1ps
module comparator_mode_control_bench;
   reg clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, raw = 1'b0;
   reg [7:0] awa = 8'h00, ara = 8'h00;
   reg [31:0] wd = 32'h0, e;
   integer checked = 0, n_mismatch = 0;
   wire awr, wrd, bv, arr, rv, cmp, fast, slow, pdac, mdac, mgnd, dacen, irq;
   wire [1:0] br, rr, spm;
   wire [5:0] lvl;
   wire [31:0] rd;
   wire [3:0] psel, msel, rsel;
   comparator_mode_control dut_u (.CORE_CLK_IN(clk), .NRST_IN(nrst), .S_AXI_AWADDR_IN(awa),
      .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hf),
      .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
      .S_AXI_BREADY_IN(1'b1), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
      .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(1'b1),
      .CMP_RAW_IN(raw), .CMP_OUT(cmp), .SPEED_POWER_MODE_OUT(spm), .FASTEST_MODE_OUT(fast),
      .SLOWEST_MODE_OUT(slow), .PLUS_MUX_SEL_OUT(psel), .PLUS_FROM_DAC_OUT(pdac), .MINUS_MUX_SEL_OUT(msel),
      .MINUS_FROM_DAC_OUT(mdac), .MINUS_TO_GND_OUT(mgnd), .DAC_ENABLE_OUT(dacen), .DAC_REF_SEL_OUT(rsel),
      .DAC_LEVEL_OUT(lvl), .IRQ_OUT(irq));
   task ck(input string nm, input logic [31:0] s, x);
      checked = checked + 1;
      if (s !== x) begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask
   task complete_run;
      $display("checks %0d fails %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task limit(input integer i);
      if (i != 100) begin
         n_mismatch = n_mismatch + 1;
         complete_run;
      end
   endtask
   // bready and rready stay high, so each answer is taken when first seen
   task axw(input [7:0] a, input [31:0] d, input [1:0] x = 2'h0);
      integer i;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      for (i = 0; i < 20; i = i + 1) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         if (bv) i = 99;
      end
      limit(i);
      ck("bresp", 32'(br), 32'(x));
   endtask
   task axr(input [7:0] a, input [31:0] d, input [1:0] x = 2'h0);
      integer i;
      ara <= a;
      arv <= 1'b1;
      for (i = 0; i < 20; i = i + 1) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv) i = 99;
      end
      limit(i);
      ck("rdata", rd, d);
      ck("rresp", 32'(rr), 32'(x));
   endtask
   // covers the input synchroniser and flag latency
   task irq_is(input logic v);
      repeat (8) @(posedge clk);
      ck("irq", 32'(irq), 32'(v));
   endtask
   task t_reset;
      ck("spm", 32'(spm), 32'h2);
      axw(8'h40, 32'hff, 2'h2);
      axr(8'h40, 32'h0, 2'h2);
      axr(8'h10, 32'h0);
      ck("level", 32'(lvl), 32'h0);
      axr(8'h00, 32'h2);
      axr(8'h0c, 32'hff);
   endtask
   task t_modes;
      integer m;
      for (m = 0; m < 4; m = m + 1) begin
         axw(8'h00, m);
         @(posedge clk);
         e = 32'({m[1:0], m == 0, m == 3});
         ck("mode", 32'({spm, fast, slow}), e);
      end
   endtask
   task t_route;
      integer r;
      axw(8'h0c, 32'h5a);
      axw(8'h10, 32'hff);
      axr(8'h10, 32'h3f);
      ck("level", 32'(lvl), 32'h3f);
      for (r = 0; r < 4; r = r + 1) begin
         axw(8'h00, r * 4);
         @(posedge clk);
         e = 32'({r == 2, r == 3, r == 1, r > 1, (r == 2 ? 4'ha : r == 3 ? 4'h5 : 4'h0), 4'ha, 4'h5});
         ck("route", 32'({pdac, mdac, mgnd, dacen, rsel, psel, msel}), e);
      end
   endtask
   task t_irq;
      axw(8'h08, 32'h3);
      axw(8'h00, 32'h22);
      raw <= 1'b1;
      irq_is(1'b1);
      axw(8'h08, 32'h2);
      irq_is(1'b0);
      axr(8'h04, 32'h1);
      axw(8'h08, 32'h3);
      axw(8'h04, 32'h1);
      raw <= 1'b0;
      irq_is(1'b0);
      axr(8'h04, 32'h2);
      axw(8'h00, 32'h12);
      irq_is(1'b1);
      axw(8'h04, 32'h2);
      raw <= 1'b1;
      irq_is(1'b0);
      ck("cmp", 32'(cmp), 32'h1);
      axw(8'h00, 32'h52);
      irq_is(1'b1);
      ck("cmp", 32'(cmp), 32'h0);
      axr(8'h04, 32'h3);
   endtask
   initial forever #5 clk = ~clk;
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_modes;
      t_route;
      t_irq;
      complete_run;
   end
endmodule // comparator_mode_control_bench
